// [design/ext_alu_pkg.sv]
package ext_alu_pkg;

   // ------------------------------------------------------------
   // Register word indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_MEM_ADDR = 3'h1;
   localparam logic [2:0] REG_ACC = 3'h2;
   localparam logic [2:0] REG_FLAGS = 3'h3;
   localparam logic [2:0] REG_MEM_DATA = 3'h4;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BIT_LSB = 4;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [4:0] FLAGS_RST = 5'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ext_add_carry_to_acc = 4'h0,
      ext_add_carry_to_mem = 4'h1,
      ext_add_to_acc = 4'h2,
      ext_add_to_mem = 4'h3,
      ext_and_to_acc = 4'h4,
      ext_and_to_mem = 4'h5,
      ext_clear_mem = 4'h6,
      ext_clear_bit = 4'h7,
      ext_invert_mem = 4'h8,
      ext_invert_to_acc = 4'h9
   } op_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_FETCH = 4'b0010,
      S_EXEC = 4'b0100,
      S_ACK = 4'b1000
   } state_t;

   // Bit 0 carry up to bit 4 special carry
   typedef struct packed {
      logic special_carry_flag;
      logic overflow_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } flags_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [2:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_t;

endpackage

// [design/data_mem.sv]
`timescale 1ns/10ps
module data_mem #(
   parameter int ADDR_W = 10
) (
   // Clock
   input wire logic core_clk,
   // Write port
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [ADDR_W-1:0] raddr,
   output logic [7:0] rdata_q
);

   logic [7:0] mem [0:(1<<ADDR_W)-1];

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end

endmodule

// [design/ext_alu.sv]
`timescale 1ns/10ps
module ext_alu import ext_alu_pkg::*; #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [2:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest
);

   typedef struct packed {
      state_t st;
      av_req_t req;
      op_t op;
      logic [2:0] bit_sel;
      logic [ADDR_W-1:0] maddr;
      logic [7:0] accumulator;
      flags_t fl;
      logic exe;
      logic [7:0] opnd;
      logic [7:0] res;
      flags_t res_fl;
      logic to_acc;
      logic to_mem;
      logic [31:0] rdata;
      logic wreq;
   } core_t;

   localparam core_t CORE_RST = '{
      st: S_IDLE,
      req: '0,
      op: ext_add_carry_to_acc,
      bit_sel: 3'h0,
      maddr: '0,
      accumulator: ACC_RST,
      fl: flags_t'(FLAGS_RST),
      exe: 1'h0,
      opnd: 8'h00,
      res: 8'h00,
      res_fl: flags_t'(FLAGS_RST),
      to_acc: 1'h0,
      to_mem: 1'h0,
      rdata: 32'h0000_0000,
      wreq: 1'h1
   };

   core_t s_q;
   core_t s_d;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;

   // ------------------------------------------------------------
   // Data memory, one flat space
   // ------------------------------------------------------------
   // Full-width address, so no section or bank select exists
   data_mem #(.ADDR_W(ADDR_W)) u_mem (
      .core_clk(core_clk),
      .we(mem_we),
      .waddr(s_q.maddr),
      .wdata(mem_wdata),
      .raddr(s_q.maddr),
      .rdata_q(mem_rdata)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      op_t nop;
      logic cin;
      logic [8:0] sum;
      logic [4:0] half;
      logic [7:0] a;
      logic [7:0] m;
      nop = op_t'(s_q.req.writedata[CMD_OP_LSB +: 4]);
      cin = 1'h0;
      sum = 9'h000;
      half = 5'h00;
      a = s_q.accumulator;
      m = mem_rdata;
      s_d = s_q;
      mem_we = 1'h0;
      mem_wdata = s_q.res;
      case (s_q.st)
         S_IDLE: begin
            if (read || write) begin
               s_d.req = '{read, write, address, writedata, byteenable};
               s_d.st = S_FETCH;
            end
         end
         S_FETCH: begin
            // Read data of the current address lands next cycle
            s_d.st = S_EXEC;
         end
         S_EXEC: begin
            s_d.opnd = m;
            s_d.exe = s_q.req.write && s_q.req.address == REG_CMD
                      && s_q.req.byteenable[0];
            s_d.res = s_q.accumulator;
            s_d.res_fl = s_q.fl;
            s_d.to_acc = 1'h0;
            s_d.to_mem = 1'h0;
            if (s_d.exe) begin
               s_d.op = nop;
               s_d.bit_sel = s_q.req.writedata[CMD_BIT_LSB +: 3];
            end
            if (nop == ext_add_carry_to_acc || nop == ext_add_carry_to_mem) begin
               cin = s_q.fl.carry_flag;
            end
            sum = {1'h0, a} + {1'h0, m} + {8'h00, cin};
            half = {1'h0, a[3:0]} + {1'h0, m[3:0]} + {4'h0, cin};
            case (nop)
               ext_add_carry_to_acc, ext_add_carry_to_mem,
               ext_add_to_acc, ext_add_to_mem: begin
                  s_d.res = sum[7:0];
                  s_d.res_fl.carry_flag = sum[8];
                  s_d.res_fl.half_carry_flag = half[4];
                  s_d.res_fl.overflow_flag = (a[7] == m[7]) && (sum[7] != a[7]);
                  // Special carry is the true sign of the signed sum
                  s_d.res_fl.special_carry_flag =
                     s_d.res_fl.overflow_flag ^ sum[7];
                  s_d.to_acc = nop == ext_add_carry_to_acc
                               || nop == ext_add_to_acc;
                  s_d.to_mem = !s_d.to_acc;
               end
               ext_and_to_acc, ext_and_to_mem: begin
                  s_d.res = a & m;
                  s_d.to_acc = nop == ext_and_to_acc;
                  s_d.to_mem = nop == ext_and_to_mem;
               end
               ext_clear_mem: begin
                  s_d.res = 8'h00;
                  s_d.to_mem = 1'h1;
               end
               ext_clear_bit: begin
                  s_d.res = m & ~(8'h01 << s_d.bit_sel);
                  s_d.to_mem = 1'h1;
               end
               ext_invert_mem: begin
                  s_d.res = ~m;
                  s_d.to_mem = 1'h1;
               end
               ext_invert_to_acc: begin
                  s_d.res = ~m;
                  s_d.to_acc = 1'h1;
               end
               default: begin
                  s_d.res = s_q.accumulator;
               end
            endcase
            // Clears leave all flags alone
            if (nop != ext_clear_mem && nop != ext_clear_bit
                && (s_d.to_acc || s_d.to_mem)) begin
               s_d.res_fl.zero_flag = s_d.res == 8'h00;
            end
            case (s_q.req.address)
               REG_CMD: s_d.rdata = {25'h0, s_q.bit_sel, s_q.op};
               REG_MEM_ADDR: s_d.rdata = 32'(s_q.maddr);
               REG_ACC: s_d.rdata = {24'h0, s_q.accumulator};
               REG_FLAGS: s_d.rdata = {27'h0, s_q.fl};
               REG_MEM_DATA: s_d.rdata = {24'h0, m};
               default: s_d.rdata = 32'h0000_0000;
            endcase
            if (!s_q.req.read) begin
               s_d.rdata = 32'h0000_0000;
            end
            s_d.wreq = 1'h0;
            s_d.st = S_ACK;
         end
         S_ACK: begin
            // Side effects other than the op and bit_sel latch (one edge earlier, entering S_ACK) take place on the accepting edge
            if (s_q.exe) begin
               s_d.fl = s_q.res_fl;
               if (s_q.to_acc) begin
                  s_d.accumulator = s_q.res;
               end
               mem_we = s_q.to_mem;
            end else if (s_q.req.write) begin
               case (s_q.req.address)
                  REG_MEM_ADDR: begin
                     if (s_q.req.byteenable[0]) begin
                        s_d.maddr[7:0] = s_q.req.writedata[7:0];
                     end
                     if (s_q.req.byteenable[1]) begin
                        s_d.maddr[ADDR_W-1:8] =
                           s_q.req.writedata[ADDR_W-1:8];
                     end
                  end
                  REG_ACC: begin
                     if (s_q.req.byteenable[0]) begin
                        s_d.accumulator = s_q.req.writedata[7:0];
                     end
                  end
                  REG_FLAGS: begin
                     if (s_q.req.byteenable[0]) begin
                        s_d.fl = flags_t'(s_q.req.writedata[4:0]);
                     end
                  end
                  REG_MEM_DATA: begin
                     mem_we = s_q.req.byteenable[0];
                     mem_wdata = s_q.req.writedata[7:0];
                  end
                  default: begin
                     mem_we = 1'h0;
                  end
               endcase
            end
            s_d.exe = 1'h0;
            s_d.wreq = 1'h1;
            s_d.st = S_IDLE;
         end
         default: begin
            s_d = CORE_RST;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= CORE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata = s_q.rdata;
   assign waitrequest = s_q.wreq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   logic commit;
   assign commit = s_q.st == S_ACK && s_q.exe;

   a_adc_acc_sum: assert property (commit && s_q.op == ext_add_carry_to_acc
      |=> s_q.accumulator == 8'($past(s_q.accumulator) + $past(s_q.opnd)
          + {7'h00, $past(s_q.fl.carry_flag)}))
      else $error("add with carry to accumulator wrong");
   a_adc_mem_sum: assert property (commit && s_q.op == ext_add_carry_to_mem
      |-> mem_we && mem_wdata == 8'(s_q.accumulator + s_q.opnd
          + {7'h00, s_q.fl.carry_flag}))
      else $error("add with carry to memory wrong");
   a_add_acc_carry: assert property (commit && s_q.op == ext_add_to_acc
      |=> {s_q.fl.carry_flag, s_q.accumulator} ==
          {1'h0, $past(s_q.accumulator)} + {1'h0, $past(s_q.opnd)})
      else $error("add to accumulator wrong");
   a_add_mem_only: assert property (commit && s_q.op == ext_add_to_mem
      |-> mem_we && mem_wdata == 8'(s_q.accumulator + s_q.opnd)
          ##1 s_q.accumulator == $past(s_q.accumulator))
      else $error("add to memory wrong");
   a_and_acc_flags: assert property (commit && s_q.op == ext_and_to_acc
      |=> s_q.accumulator == ($past(s_q.accumulator) & $past(s_q.opnd))
          && s_q.fl.carry_flag == $past(s_q.fl.carry_flag)
          && s_q.fl.overflow_flag == $past(s_q.fl.overflow_flag))
      else $error("and to accumulator wrong");
   a_and_mem_data: assert property (commit && s_q.op == ext_and_to_mem
      |-> mem_we && mem_wdata == (s_q.accumulator & s_q.opnd))
      else $error("and to memory wrong");
   a_clear_keeps_flags: assert property (commit && s_q.op == ext_clear_mem
      |-> mem_we && mem_wdata == 8'h00
          ##1 s_q.fl == $past(s_q.fl))
      else $error("byte clear wrong");
   a_clear_one_bit: assert property (commit && s_q.op == ext_clear_bit
      |-> mem_wdata == (s_q.opnd & ~(8'h01 << s_q.bit_sel))
          && !mem_wdata[s_q.bit_sel])
      else $error("bit clear wrong");
   a_invert_mem_zero: assert property (commit && s_q.op == ext_invert_mem
      |-> mem_we && mem_wdata == ~s_q.opnd
          ##1 s_q.fl.zero_flag == ($past(s_q.opnd) == 8'hFF))
      else $error("invert in place wrong");
   a_invert_acc_only: assert property (commit && s_q.op == ext_invert_to_acc
      |-> !mem_we ##1 s_q.accumulator == ~$past(s_q.opnd))
      else $error("invert to accumulator wrong");
   a_zero_flag_value: assert property (commit
      && s_q.op inside {ext_add_to_acc, ext_and_to_mem, ext_add_carry_to_mem}
      |=> s_q.fl.zero_flag == ($past(s_q.res) == 8'h00))
      else $error("zero flag wrong");
   a_answer_time: assert property ($rose(s_q.st == S_FETCH)
      |-> ##2 !waitrequest ##1 waitrequest)
      else $error("answer latency wrong");

   c_adc_carry_in: cover property (commit
      && s_q.op == ext_add_carry_to_mem && s_q.fl.carry_flag);
   c_invert_acc: cover property (commit && s_q.op == ext_invert_to_acc);
   c_mem_readback: cover property (s_q.st == S_ACK && s_q.req.read
      && s_q.req.address == REG_MEM_DATA);

endmodule

// [testbench/ext_alu_tb_top.sv]
`timescale 1ns/10ps
module ext_alu_tb_top import ext_alu_pkg::*;;
   logic core_clk;
   logic sys_rst;
   logic [2:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   int n_fail;
   int tests_run;
   int seed;

   ext_alu #(.ADDR_W(10)) dut (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest)
   );

   // ------------------------------------------------------------
   // Clock, watchdog, report
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // About 6300 cycles expected; generous margin
   initial begin
      #3000000;
      n_fail++;
      $display("Error watchdog expected done seen hang");
      final_report();
   end

   task automatic final_report();
      $display("Checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Bus master and compare
   // ------------------------------------------------------------
   // Waits an edge first so a release never meets a new raise
   task automatic bus(input logic wr, input logic [2:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge core_clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 20);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (k >= 20) begin
         n_fail++;
         $display("Error waitrequest expected 0 seen 1");
      end
   endtask

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // ------------------------------------------------------------
   // One operation against the integer model
   // ------------------------------------------------------------
   task automatic exec(input int op, input int bitn, input int ad,
                       input int a, input int m, input int f);
      logic [31:0] q;
      int cin, s, r, nf, ea, em;
      cin = (op < 2) ? (f & 1) : 0;
      nf = f;
      ea = a;
      em = m;
      r = 0;
      if (op <= 3) begin
         s = a + m + cin;
         r = s & 8'hFF;
         nf = (s >> 8) | ((((a & 15) + (m & 15) + cin) >> 4) << 1);
         nf |= (((a >> 7) == (m >> 7)) && ((r >> 7) != (a >> 7))) << 3;
         nf |= (((nf >> 3) & 1) ^ (r >> 7)) << 4;
      end else if (op <= 5) begin
         r = a & m;
      end else if (op == 6) begin
         r = 0;
      end else if (op == 7) begin
         r = m & ~(1 << bitn) & 8'hFF;
      end else if (op <= 9) begin
         r = ~m & 8'hFF;
      end
      if ((op <= 5 || op == 8 || op == 9)) begin
         nf = (nf & 5'h1B) | ((r == 0) << 2);
      end
      if (op == 0 || op == 2 || op == 4 || op == 9) ea = r;
      if (op == 1 || op == 3 || (op >= 5 && op <= 8)) em = r;
      bus(1'b1, REG_MEM_ADDR, 32'(ad), q);
      bus(1'b1, REG_ACC, 32'(a), q);
      bus(1'b1, REG_FLAGS, 32'(f), q);
      bus(1'b1, REG_MEM_DATA, 32'(m), q);
      bus(1'b1, REG_CMD, 32'((bitn << CMD_BIT_LSB) | op), q);
      bus(1'b0, REG_ACC, 32'h0, q);
      chk("accumulator", 8'(ea), q[7:0]);
      bus(1'b0, REG_FLAGS, 32'h0, q);
      chk("flags", 8'(nf), {3'h0, q[4:0]});
      bus(1'b0, REG_MEM_DATA, 32'h0, q);
      chk("memory", 8'(em), q[7:0]);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      int op, a, m, f, ad, b;
      seed = 56174;
      n_fail = 0;
      tests_run = 0;
      sys_rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 3'h0;
      writedata = 32'h0;
      byteenable = 4'hF;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(1'b0, REG_ACC, 32'h0, q);
      chk("acc reset", ACC_RST, q[7:0]);
      bus(1'b0, REG_FLAGS, 32'h0, q);
      chk("flags reset", {3'h0, FLAGS_RST}, {3'h0, q[4:0]});
      $display("Test reset done");
      // Every opcode, random operands, whole address range
      for (int i = 0; i < 150; i++) begin
         op = i % 10;
         a = $random(seed) & 8'hFF;
         m = $random(seed) & 8'hFF;
         f = $random(seed) & 5'h1F;
         ad = $random(seed) & 10'h3FF;
         b = $random(seed) & 7;
         if (i % 3 == 0) begin
            // Force a zero result to exercise the zero flag
            if (op >= 4 && op <= 5) m = ~a & 8'hFF;
            else if (op >= 8) m = 8'hFF;
            else if (op <= 3) m = (256 - a - ((op < 2) ? f & 1 : 0)) & 8'hFF;
         end
         exec(op, b, ad, a, m, f);
      end
      $display("Test operations done");
      // Unused opcodes leave everything alone
      for (int i = 10; i < 16; i++) begin
         exec(i, 0, $random(seed) & 10'h3FF, $random(seed) & 8'hFF,
              $random(seed) & 8'hFF, $random(seed) & 5'h1F);
      end
      $display("Test unused opcodes done");
      // Unmapped words read zero and ignore writes
      bus(1'b1, REG_ACC, 32'h5A, q);
      for (int i = 5; i < 8; i++) begin
         bus(1'b1, 3'(i), 32'hFF, q);
         bus(1'b0, 3'(i), 32'h0, q);
         chk("unmapped", 8'h00, q[7:0]);
      end
      bus(1'b0, REG_ACC, 32'h0, q);
      chk("acc after unmapped", 8'h5A, q[7:0]);
      $display("Test unmapped done");
      final_report();
   end
endmodule
